// File: src/led_matrix_cfg.svh
// Offsets, field positions, reset values and timing counts of the LED signal matrix.
// Included by the package, the checker and the bench files; definitions only.
`ifndef LED_MATRIX_CFG_SVH
`define LED_MATRIX_CFG_SVH

`define LED_COUNT 14
`define CHAN_COUNT 28
`define OBJ_COUNT 8
`define SRC_WIDTH 64

`define CLK_FREQ_KHZ 25000
`define LED_DELAY_MS 10
`define LED_DELAY_CYCLES (`LED_DELAY_MS * `CLK_FREQ_KHZ)
`define BLINK_HALF_MS 250
`define BLINK_HALF_TICKS (`BLINK_HALF_MS / `LED_DELAY_MS)

`define REG_CTRL 12'h000
`define REG_IRQ_STATUS 12'h004
`define REG_IRQ_MASK 12'h008
`define REG_LATCHED 12'h00c
`define REG_LED_STATE 12'h010
`define REG_INHIBIT 12'h014
`define REG_CHAN_BASE 12'h040
`define REG_CHAN_LAST 12'h0ac
`define REG_OBJ_BASE 12'h100
`define REG_OBJ_LAST 12'h13c

`define CTRL_RELEASE_BIT 0
`define IRQ_LATCH_SET_BIT 0
`define IRQ_RELEASE_BIT 1
`define IRQ_INHIBIT_BIT 2
`define IRQ_MASK_RESET 3'h0

`define PULSE_SRC_MASK 64'h03c0_0000_0000_0000
`define LOCAL_SRC_BIT 63

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: src/led_matrix_pkg.sv
// Types shared by the LED signal matrix and its tick generator.
// Assumes led_matrix_cfg.svh supplies the sizes.
`include "led_matrix_cfg.svh"

package led_matrix_pkg;

	// Signal sources as delivered by the surrounding logic (63 bits)
	typedef struct packed {
		logic [4:0] com_active;
		logic [3:0] obj_cmd_pulse;
		logic [3:0] obj_failure;
		logic [1:0] func_button;
		logic [7:0] virtual_in;
		logic [7:0] digital_in;
		logic [5:0] stage_trip;
		logic [5:0] stage_start;
		logic [19:0] logic_out;
	} src_in_type;

	// One source-to-indicator connection
	typedef struct packed {
		logic store;
		logic blink;
		logic latch;
		logic enable;
		logic [1:0] spare;
		logic [5:0] src;
	} chan_cfg_type;

	typedef struct packed {
		logic [17:0] count;
		logic [4:0] blink_count;
		logic phase;
		logic tick;
	} tick_state_type;

	typedef struct packed {
		chan_cfg_type [`CHAN_COUNT-1:0] cfg;
		logic [`OBJ_COUNT-1:0][`SRC_WIDTH-1:0] obj_mask;
		logic [`CHAN_COUNT-1:0] latched;
		logic [`CHAN_COUNT-1:0] led;
		logic [`OBJ_COUNT-1:0] inhibit;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic release_pulse;
		logic aw_held;
		logic [11:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} core_state_type;

endpackage

// File: src/led_tick_gen.sv
// Update tick and shared blink phase for the LED signal matrix.
// Assumes one clock; the tick period is a parameter so simulation can shorten it.
`timescale 1ns/10ps
`default_nettype none

module led_tick_gen
	import led_matrix_pkg::*;
#(
	parameter int TICK_CYCLES = `LED_DELAY_CYCLES,
	parameter int BLINK_TICKS = `BLINK_HALF_TICKS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Timing outputs
	output logic tick,
	output logic blink_on
);

	tick_state_type s_reg;
	tick_state_type s_next;

	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (s_reg.count == 18'(TICK_CYCLES - 1)) begin
			s_next.count = 18'h0;
			s_next.tick = 1'b1;
			// One phase for every blinking indicator
			if (s_reg.blink_count == 5'(BLINK_TICKS - 1)) begin
				s_next.blink_count = 5'h0;
				s_next.phase = ~s_reg.phase;
			end else begin
				s_next.blink_count = s_reg.blink_count + 5'h1;
			end
		end else begin
			s_next.count = s_reg.count + 18'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;
	assign blink_on = s_reg.phase;

endmodule

`default_nettype wire

// File: src/led_signal_matrix_latch.sv
// LED signal matrix with latch, blink and store options, plus object block matrix.
// Assumes sources synchronous to aclk and an AXI4-Lite master for the registers.
//
// Operation
// - An enabled normal connection lights its indicator while the source is high and darkens it after.
// - Indicator changes follow the source within about 10 ms in either direction.
// - A latched connection lights with its source and stays lit until a release clears it.
// - A blink connection flashes its indicator while the connection is active.
// - Stored latched states are offered for retention and reloaded after restart.
// - Storage applies only to connections that also have the latch option.
// - There are 14 indicators; connections 0 to 13 drive the green and 14 to 27 the red colour of one.
// - Each connection is set as normal, latched, blink or blink-latched.
// - Indicators are driven only through the matrix; logic outputs reach them only as sources.
// - Sources cover logic outputs 1 to 20, stage starts and trips, inputs, buttons, objects, ports.
// - A local-control source is high while local/remote selects local.
// - Sources mapped in the object block matrix inhibit open and close of their object while high.
// - Pulse-type object open and close commands never inhibit an object.
// - A panel release is honoured only when the operator is authorised, and clears every latch at once.
// - One common release clears latched indicators and latched digital outputs alike.
// - A release acts only while some latched output is active.
`timescale 1ns/10ps
`default_nettype none

module led_signal_matrix_latch
	import led_matrix_pkg::*;
#(
	parameter int TICK_CYCLES = `LED_DELAY_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Signal sources
	input wire src_in_type sources,
	input wire logic local_selected,
	// Release requests
	input wire logic release_input,
	input wire logic release_remote,
	input wire logic panel_release,
	input wire logic panel_authorised,
	// Retained storage
	input wire logic [`CHAN_COUNT-1:0] retain_restore,
	output logic [`CHAN_COUNT-1:0] retain_save,
	// Indicators, object inhibits, latch release, interrupt
	output logic [`LED_COUNT-1:0] led_green,
	output logic [`LED_COUNT-1:0] led_red,
	output logic [`OBJ_COUNT-1:0] obj_inhibit,
	output logic latch_release,
	output logic irq
);

	core_state_type s_reg;
	core_state_type s_next;
	logic tick;
	logic blink_on;

	led_tick_gen #(
		.TICK_CYCLES(TICK_CYCLES),
		.BLINK_TICKS(`BLINK_HALF_TICKS)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick),
		.blink_on(blink_on)
	);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
			input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] result;
		result = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				result[8*b +: 8] = new_val[8*b +: 8];
			end
		end
		return result;
	endfunction

	function automatic logic is_chan(input logic [11:0] addr);
		return addr[11:2] >= `REG_CHAN_BASE >> 2 && addr[11:2] <= `REG_CHAN_LAST >> 2;
	endfunction

	function automatic logic is_obj(input logic [11:0] addr);
		return addr[11:2] >= `REG_OBJ_BASE >> 2 && addr[11:2] <= `REG_OBJ_LAST >> 2;
	endfunction

	function automatic logic [4:0] chan_index(input logic [11:0] addr);
		logic [11:0] off;
		off = addr - `REG_CHAN_BASE;
		return off[6:2];
	endfunction

	function automatic logic [3:0] obj_index(input logic [11:0] addr);
		logic [11:0] off;
		off = addr - `REG_OBJ_BASE;
		return off[5:2];
	endfunction

	function automatic logic is_mapped(input logic [11:0] addr);
		logic [11:0] w;
		w = {addr[11:2], 2'b00};
		return w == `REG_CTRL || w == `REG_IRQ_STATUS || w == `REG_IRQ_MASK
			|| w == `REG_LATCHED || w == `REG_LED_STATE || w == `REG_INHIBIT
			|| is_chan(addr) || is_obj(addr);
	endfunction

	// Sources, with the local-control flag made here
	logic [`SRC_WIDTH-1:0] src_vec;
	assign src_vec = {local_selected, sources};

	logic [`CHAN_COUNT-1:0] active;
	logic [`CHAN_COUNT-1:0] latch_opt;
	logic [`CHAN_COUNT-1:0] blink_opt;
	logic [`CHAN_COUNT-1:0] store_opt;

	always_comb begin
		for (int i = 0; i < `CHAN_COUNT; i++) begin
			active[i] = s_reg.cfg[i].enable & src_vec[s_reg.cfg[i].src];
			latch_opt[i] = s_reg.cfg[i].latch;
			blink_opt[i] = s_reg.cfg[i].blink;
			store_opt[i] = s_reg.cfg[i].store & s_reg.cfg[i].latch;
		end
	end

	logic release_req;
	logic do_release;
	logic [`CHAN_COUNT-1:0] new_latch;
	logic [`CHAN_COUNT-1:0] restore_set;
	logic [`OBJ_COUNT-1:0] inhibit_now;
	logic [2:0] events;
	logic sw_release;
	logic status_read;
	logic [31:0] rd_word;
	logic [31:0] old_word;
	logic [31:0] wr_word;
	logic [4:0] ci;
	logic [3:0] oi;

	assign s_axi_awready = !s_reg.aw_held && !s_reg.bvalid;
	assign s_axi_wready = !s_reg.w_held && !s_reg.bvalid;
	assign s_axi_arready = !s_reg.rvalid;

	always_comb begin
		s_next = s_reg;
		s_next.release_pulse = 1'b0;
		sw_release = 1'b0;
		restore_set = '0;
		status_read = 1'b0;
		rd_word = 32'h0;
		old_word = 32'h0;
		wr_word = 32'h0;
		ci = 5'h0;
		oi = 4'h0;

		// Write address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_held = 1'b1;
			s_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_held = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_held && s_reg.w_held) begin
			s_next.aw_held = 1'b0;
			s_next.w_held = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = is_mapped(s_reg.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
			ci = chan_index(s_reg.awaddr);
			oi = obj_index(s_reg.awaddr);
			if (is_chan(s_reg.awaddr)) begin
				old_word = {20'h0, s_reg.cfg[ci]};
			end else if (is_obj(s_reg.awaddr)) begin
				old_word = s_reg.obj_mask[oi[3:1]][32*oi[0] +: 32];
			end else if ({s_reg.awaddr[11:2], 2'b00} == `REG_IRQ_MASK) begin
				old_word = {29'h0, s_reg.irq_mask};
			end
			wr_word = merge_bytes(old_word, s_reg.wdata, s_reg.wstrb);
			if (is_chan(s_reg.awaddr)) begin
				s_next.cfg[ci] = chan_cfg_type'({wr_word[11:8], 2'b00, wr_word[5:0]});
				// Options are lost at restart, so the retained state reloads when set again
				restore_set[ci] = wr_word[11] & wr_word[9] & retain_restore[ci];
			end else if (is_obj(s_reg.awaddr)) begin
				s_next.obj_mask[oi[3:1]][32*oi[0] +: 32] = wr_word;
			end else if ({s_reg.awaddr[11:2], 2'b00} == `REG_IRQ_MASK) begin
				s_next.irq_mask = wr_word[2:0];
			end else if ({s_reg.awaddr[11:2], 2'b00} == `REG_CTRL) begin
				sw_release = s_reg.wstrb[0] & s_reg.wdata[`CTRL_RELEASE_BIT];
			end
		end

		// Reads answer one cycle after the address is taken
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			ci = chan_index(s_axi_araddr);
			oi = obj_index(s_axi_araddr);
			unique case ({s_axi_araddr[11:2], 2'b00})
				`REG_IRQ_STATUS: begin
					rd_word = {29'h0, s_reg.irq_status};
					status_read = 1'b1;
				end
				`REG_IRQ_MASK: rd_word = {29'h0, s_reg.irq_mask};
				`REG_LATCHED: rd_word = {4'h0, s_reg.latched};
				`REG_LED_STATE: rd_word = {4'h0, s_reg.led};
				`REG_INHIBIT: rd_word = {24'h0, s_reg.inhibit};
				default: begin
					if (is_chan(s_axi_araddr)) begin
						rd_word = {20'h0, s_reg.cfg[ci]};
					end else if (is_obj(s_axi_araddr)) begin
						rd_word = s_reg.obj_mask[oi[3:1]][32*oi[0] +: 32];
					end
				end
			endcase
			s_next.rvalid = 1'b1;
			s_next.rdata = rd_word;
			s_next.rresp = is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end

		// Common release; a panel request needs authorisation
		release_req = sw_release | release_input | release_remote
			| (panel_release & panel_authorised);
		do_release = release_req & (|s_reg.latched);
		s_next.release_pulse = do_release;

		// A source still high during release re-latches at once: set wins
		new_latch = active & latch_opt;
		s_next.latched = (s_reg.latched & ~{`CHAN_COUNT{do_release}}) | new_latch
			| restore_set;

		// Indicators refresh on the 10 ms tick, giving the documented lag
		if (tick) begin
			for (int i = 0; i < `CHAN_COUNT; i++) begin
				s_next.led[i] = (s_reg.latched[i] | active[i])
					& (~blink_opt[i] | blink_on);
			end
		end

		// Pulse-type object commands are stripped from every inhibit mask
		for (int o = 0; o < `OBJ_COUNT; o++) begin
			inhibit_now[o] = |(src_vec & s_reg.obj_mask[o] & ~`PULSE_SRC_MASK);
		end
		s_next.inhibit = inhibit_now;

		events = 3'h0;
		events[`IRQ_LATCH_SET_BIT] = |((new_latch | restore_set) & ~s_reg.latched);
		events[`IRQ_RELEASE_BIT] = do_release;
		events[`IRQ_INHIBIT_BIT] = |(inhibit_now & ~s_reg.inhibit);
		s_next.irq_status = (s_reg.irq_status & ~{3{status_read}}) | events;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.irq_mask <= `IRQ_MASK_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign led_green = s_reg.led[`LED_COUNT-1:0];
	assign led_red = s_reg.led[`CHAN_COUNT-1:`LED_COUNT];
	assign obj_inhibit = s_reg.inhibit;
	assign latch_release = s_reg.release_pulse;
	assign retain_save = s_reg.latched & store_opt;
	assign irq = |(s_reg.irq_status & s_reg.irq_mask);

endmodule

`default_nettype wire

// File: sim/led_signal_matrix_latch_asserts.sv
// Port-level checks of the LED signal matrix.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/10ps
`default_nettype none
`include "led_matrix_cfg.svh"

module led_signal_matrix_latch_asserts
	import led_matrix_pkg::*;
#(
	parameter int TICK_CYCLES = 20
) (
	// Clock, reset and bus handshakes
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Sources and release requests
	input wire src_in_type sources,
	input wire logic local_selected,
	input wire logic release_input,
	input wire logic release_remote,
	input wire logic panel_release,
	input wire logic panel_authorised,
	// Outputs
	input wire logic [`LED_COUNT-1:0] led_green,
	input wire logic [`LED_COUNT-1:0] led_red,
	input wire logic [`OBJ_COUNT-1:0] obj_inhibit,
	input wire logic latch_release,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [27:0] prev_reg;
	logic [31:0] since_reg;
	logic seen_reg;
	wire logic led_moved = prev_reg != {led_red, led_green};
	wire logic rel_req = release_input || release_remote || (panel_release && panel_authorised);

	// Indicators only move on update ticks, so two changes are a full tick apart
	always_ff @(posedge aclk) begin
		prev_reg <= {led_red, led_green};
		since_reg <= (!aresetn || led_moved) ? 32'h0 : since_reg + 32'h1;
		seen_reg <= aresetn && (seen_reg || led_moved);
	end

	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	chk_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered next cycle");
	chk_inhibit_cause: assert property ((({local_selected, sources} & ~`PULSE_SRC_MASK) == '0) |=> obj_inhibit == '0)
		else $error("object inhibit without a level source");
	chk_release_cause: assert property (latch_release |-> $past(rel_req) || $past(s_axi_bvalid) || s_axi_bvalid)
		else $error("latch release without a request");
	chk_led_spacing: assert property (seen_reg && led_moved |-> since_reg >= TICK_CYCLES - 1)
		else $error("indicator changed between ticks");
	chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && !latch_release && obj_inhibit == '0 && led_green == '0)
		else $error("outputs active right after reset");

	cover property (latch_release);
	cover property (obj_inhibit != '0);
	cover property (irq);
endmodule

bind led_signal_matrix_latch led_signal_matrix_latch_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.*);

`default_nettype wire

// File: sim/led_source_model.sv
// Source side model: stages, inputs and logic outputs feeding the matrix.
// Assumes the bench sets wanted levels; outputs move just after aclk.
`timescale 1ns/10ps
`default_nettype none

module led_source_model
	import led_matrix_pkg::*;
(
	// Clock and wanted levels, bit 63 is the local/remote switch
	input wire logic aclk,
	input wire logic [63:0] want,
	// Towards the matrix
	output var src_in_type sources,
	output logic local_selected
);
	logic [3:0] cmd_prev_reg = 4'h0;

	always_ff @(posedge aclk) begin
		sources <= want[62:0];
		// Object commands only last one cycle however long the request stays
		sources.obj_cmd_pulse <= want[57:54] & ~cmd_prev_reg;
		cmd_prev_reg <= want[57:54];
		local_selected <= want[63];
	end
endmodule

`default_nettype wire

// File: sim/led_signal_matrix_latch_bench.sv
// Self-checking bench of the LED signal matrix with its source model.
// Assumes design, checker and model compiled first; one 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "led_matrix_cfg.svh"

module led_signal_matrix_latch_bench;
	import led_matrix_pkg::*;
	localparam int TICK = 20;
	logic aclk = 1'h0, aresetn = 1'h0, p = 1'h0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic release_input = 0, release_remote = 0, panel_release = 0, panel_authorised = 0;
	logic [27:0] retain_restore = '0, retain_save;
	logic [13:0] led_green, led_red;
	logic [7:0] obj_inhibit;
	logic latch_release, irq, local_selected;
	logic [63:0] want = '0;
	src_in_type sources;
	int n_errors = 0, num_checks = 0, hits, ch, k, o;

	led_source_model src_i (.aclk(aclk), .want(want), .sources(sources), .local_selected(local_selected));
	led_signal_matrix_latch #(.TICK_CYCLES(TICK)) DUT (.*);

	initial forever #20 aclk = ~aclk;

	function automatic logic [31:0] cfgw(int s, logic l, logic b, logic st);
		return {20'h0, st, b, l, 1'h1, 2'h0, 6'(s)};
	endfunction

	function automatic logic led_at(int c);
		logic [27:0] all;
		all = {led_red, led_green};
		return all[c];
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One AXI4-Lite write (wr=1) or read; response code in r, read data in d
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] val);
		logic ta, tw, tr, done;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, val};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {wr, wr, wr, !wr, !wr};
		done = 0;
		while (!done) begin
			@(negedge aclk);
			{ta, tw, tr} = {s_axi_awready, s_axi_wready, s_axi_arready};
			done = wr ? s_axi_bvalid : s_axi_rvalid;
			{r, d} = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tr) s_axi_arvalid <= 0;
		end
		{s_axi_bready, s_axi_rready} <= 2'h0;
	endtask

	task automatic src(input logic [63:0] val);
		@(posedge aclk);
		want <= val;
	endtask

	task automatic wait_led(input int c, input logic val);
		int n;
		n = 0;
		@(negedge aclk);
		while (led_at(c) !== val && n < TICK + 6) begin
			@(negedge aclk);
			n++;
		end
		chk("indicator", led_at(c), val);
	endtask

	// Drive {input, remote, panel, authorised} for two cycles, count release pulses
	task automatic pulse(input logic [3:0] req);
		hits = 0;
		@(posedge aclk);
		{release_input, release_remote, panel_release, panel_authorised} <= req;
		for (int j = 0; j < 6; j++) begin
			@(negedge aclk);
			hits += latch_release;
			@(posedge aclk);
			if (j == 1) {release_input, release_remote, panel_release, panel_authorised} <= 4'h0;
		end
	endtask

	initial begin
		repeat (40000) @(posedge aclk);
		n_errors++;
		summarize();
	end

	initial begin
		void'($urandom(67887));
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		bus(0, `REG_IRQ_MASK, 0);
		chk("mask reset", d, 32'h0);
		bus(1, 12'hffc, $urandom);
		chk("unmapped write", r, `RESP_SLVERR);
		bus(0, 12'hffc, 0);
		chk("unmapped read", r, `RESP_SLVERR);
		repeat (6) begin
			ch = $urandom_range(27);
			v = $urandom;
			bus(1, `REG_CHAN_BASE + 12'(4 * ch), v);
			bus(0, `REG_CHAN_BASE + 12'(4 * ch), 0);
			chk("channel setup", d, v & 32'h0f3f);
			bus(1, `REG_CHAN_BASE + 12'(4 * ch), 0);
		end
		for (int i = 0; i < 2; i++) begin
			ch = i * 13;
			k = i ? 63 : 32 + $urandom_range(7);
			bus(1, `REG_CHAN_BASE + 12'(4 * ch), cfgw(k, 0, 0, 0));
			src(64'h1 << k);
			wait_led(ch, 1);
			src(64'h0);
			wait_led(ch, 0);
		end
		bus(1, `REG_IRQ_MASK, 32'h1);
		for (int i = 0; i < 4; i++) begin
			if (i == 1) @(posedge aclk) retain_restore <= $urandom;
			bus(1, `REG_CHAN_BASE + 12'h038, cfgw(i, 1, 0, i == 1));
			bus(0, `REG_LATCHED, 0);
			chk("restore", d, {i == 1 && retain_restore[14], 14'h0});
			src(64'h1 << i);
			src(64'h0);
			wait_led(14, 1);
			chk("save", retain_save[14], i == 1);
			chk("irq set", irq, 1);
			bus(0, `REG_IRQ_STATUS, 0);
			chk("status", d[0], 1);
			@(negedge aclk);
			chk("irq clear", irq, 0);
			pulse(4'h2);
			chk("unauthorised", hits, 0);
			bus(0, `REG_LATCHED, 0);
			chk("held", d, 32'h4000);
			if (i < 3) begin
				pulse(i == 0 ? 4'h8 : i == 1 ? 4'h4 : 4'h3);
			end else begin
				bus(1, `REG_CTRL, 1);
				bus(0, `REG_IRQ_STATUS, 0);
				hits = d[1];
			end
			chk("release pulse", hits != 0, 1);
			wait_led(14, 0);
		end
		pulse(4'h4);
		chk("idle release", hits, 0);
		bus(1, `REG_CHAN_BASE + 12'h004, cfgw(40, 0, 1, 0));
		bus(1, `REG_CHAN_BASE + 12'h008, cfgw(40, 0, 1, 0));
		src(64'h1 << 40);
		{hits, k} = '0;
		repeat (120 * TICK) begin
			@(negedge aclk);
			hits += led_green[1] != p;
			p = led_green[1];
			k += led_green[1] !== led_green[2];
		end
		chk("blink edges", hits >= 4, 1);
		chk("blink phase", k, 0);
		o = $urandom_range(7);
		bus(1, `REG_OBJ_BASE + 12'(8 * o) + 12'h004, 32'h0040_0002);
		src(64'h1 << 54);
		hits = 0;
		repeat (4) begin
			@(negedge aclk);
			hits += |obj_inhibit;
		end
		chk("pulse inhibit", hits, 0);
		src(64'h1 << 33);
		repeat (3) @(negedge aclk);
		chk("inhibit", obj_inhibit, 8'h1 << o);
		src(64'h0);
		repeat (3) @(negedge aclk);
		chk("inhibit off", obj_inhibit, 0);
		summarize();
	end
endmodule

`default_nettype wire
